// ### shared/gmc_defines.svh
// Offsets, field positions, reset values and timing counts of the global misc registers
`ifndef GMC_DEFINES_SVH
`define GMC_DEFINES_SVH
`define GMC_OFS_GLOBAL_CFG 12'h398
`define GMC_OFS_FRONT_PULL 12'h39c
`define GMC_OFS_REAR_PULL 12'h3a0
`define GMC_OFS_CORR_CTRL 12'h3a4
`define GMC_OFS_THERMO_TRIG 12'h3a8
`define GMC_OFS_THERMO_DATA 12'h3ac
`define GMC_OFS_FW_VERSION 12'h3fc
`define GMC_BIT_DMA_ENDIAN 0
`define GMC_BIT_ACK_MODE 1
`define GMC_BIT_CORR_BUSY 16
`define GMC_BIT_SAMPLE_GO 0
`define GMC_BIT_AUTO_SAMPLE 1
`define GMC_CORR_UNLOCK_KEY 16'habcd
`define GMC_RST_CORR_KEY 16'h0000
`define GMC_RST_PULL 2'h0
`define GMC_CLK_HZ 100000000
`define GMC_AUTO_PERIOD_S 1
`define GMC_AUTO_PERIOD_CYC (`GMC_CLK_HZ * `GMC_AUTO_PERIOD_S)
`endif

// ### shared/gmc_pkg.sv
// Types shared by the global misc register bank
package gmc_pkg;
  typedef enum logic [1:0] {
    GMC_PULL_FLOAT,
    GMC_PULL_5V,
    GMC_PULL_3V3,
    GMC_PULL_GND
  } gmc_pull_t;
  typedef enum logic {
    GMC_ACK_WRITE,
    GMC_ACK_READ
  } gmc_ack_t;
endpackage : gmc_pkg

// ### logic/gmc_tick_div.sv
// Divider that issues a one-cycle enable pulse every PERIOD cycles
`timescale 1ns/100ps
module gmc_tick_div #(
  parameter int PERIOD = 100000000
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run,
  output logic tick
);
  localparam int CW = $clog2(PERIOD + 1);
  logic [CW-1:0] count;
  logic at_end;

  if (PERIOD < 2) begin : g_bad_period
    $error("gmc_tick_div: PERIOD must be at least 2");
  end

  assign at_end = (count == CW'(PERIOD - 1));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= at_end ? '0 : count + CW'(1);
      tick <= at_end;
    end
  end
endmodule : gmc_tick_div

// ### logic/gmc_regs.sv
// Global miscellaneous configuration and status register bank
// Notes on behaviour
// - Config bit 1 picks interrupt acknowledge: 0 write-one clear, 1 read clear; resets 0.
// - In write-clear style a status bit clears only on a written one.
// - In read-clear style reading a status register clears its pending bits.
// - Config bit 0 selects DMA byte order; 0 little endian; resets 0.
// - Front pull field: 00 float, 01 5V, 10 3.3V, 11 ground; resets 00.
// - Rear connector pull field uses the same coding; resets 00.
// - After reset the store is copied from the EEPROM; busy bit 16 high meanwhile.
// - Correction space writes accepted only while the key field holds the unlock key.
// - Key leaving the unlock value starts an EEPROM update procedure.
// - Busy bit is high while that update accesses the EEPROM.
// - With auto sample set, temperature data refreshes once every second.
// - Without auto sample, data changes only after writing 1 to the go bit.
// - Temperature data is the 13-bit result sign-extended to 32 bits; resets 0.
// - Register value divided by 256 gives degrees Celsius.
// - Firmware version register returns major, minor, revision and build.
// - Status bits set only when enabled and the event occurs; reset 0.
`timescale 1ns/100ps
`include "gmc_defines.svh"
module gmc_regs #(
  parameter logic [31:0] FIRMWARE_BUILD_ID = 32'h0001_0000,
  parameter int AUTO_PERIOD = `GMC_AUTO_PERIOD_CYC,
  parameter int NUM_IRQ = 20
) (
  input wire logic mclk,
  input wire logic nrst,
  // Host register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Configuration outputs
  output logic dma_big_endian,
  output gmc_pkg::gmc_ack_t irq_ack_mode,
  output gmc_pkg::gmc_pull_t front_pull_select,
  output gmc_pkg::gmc_pull_t rear_pull_select,
  // Interrupt status helper for a status register elsewhere in the map
  input wire logic [NUM_IRQ-1:0] irq_event,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic irq_status_wr,
  input wire logic irq_status_rd,
  input wire logic [NUM_IRQ-1:0] irq_status_wdata,
  output logic [NUM_IRQ-1:0] irq_status,
  // Correction store engine
  output logic corr_write_allow,
  output logic corr_load_start,
  output logic corr_save_start,
  input wire logic corr_engine_busy,
  // Temperature sensor engine
  output logic thermo_read_start,
  input wire logic thermo_done,
  input wire logic [12:0] thermo_result
);
  logic cfg_ack_read;
  logic cfg_dma_big;
  logic [1:0] front_pull;
  logic [1:0] rear_pull;
  logic [15:0] corr_write_key;
  logic load_pending;
  logic corr_store_busy;
  logic thermo_auto_sample;
  logic thermo_sample_go;
  logic thermo_in_flight;
  logic [31:0] thermo_data;
  logic auto_tick;
  logic busy_sync1;
  logic busy_sync2;
  logic busy_core;
  logic await_engine;

  if (NUM_IRQ < 1 || NUM_IRQ > 32) begin : g_bad_irq
    $error("gmc_regs: NUM_IRQ out of range");
  end
  if (AUTO_PERIOD < 2) begin : g_bad_period
    $error("gmc_regs: AUTO_PERIOD too small");
  end

  wire sel_cfg = (reg_addr == `GMC_OFS_GLOBAL_CFG);
  wire sel_front = (reg_addr == `GMC_OFS_FRONT_PULL);
  wire sel_rear = (reg_addr == `GMC_OFS_REAR_PULL);
  wire sel_corr = (reg_addr == `GMC_OFS_CORR_CTRL);
  wire sel_trig = (reg_addr == `GMC_OFS_THERMO_TRIG);
  wire sel_data = (reg_addr == `GMC_OFS_THERMO_DATA);
  wire sel_fw = (reg_addr == `GMC_OFS_FW_VERSION);

  wire wr_corr = reg_wr && sel_corr;
  wire wr_trig = reg_wr && sel_trig;
  wire key_open = (corr_write_key == `GMC_CORR_UNLOCK_KEY);
  // Relock: a write moves the key away from the unlock value
  wire relock = wr_corr && key_open && !busy_core &&
    (reg_wdata[15:0] != `GMC_CORR_UNLOCK_KEY);
  wire go_write = wr_trig && reg_wdata[`GMC_BIT_SAMPLE_GO];
  // A done in the launch cycle frees the sensor, so the new request is not lost
  wire launch = (!thermo_in_flight || thermo_done) &&
    (go_write || (thermo_auto_sample && auto_tick));

  // Busy comes from an engine on slower serial timing, so synchronise it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_sync1 <= 1'b1;
      busy_sync2 <= 1'b1;
    end else begin
      busy_sync1 <= corr_engine_busy;
      busy_sync2 <= busy_sync1;
    end
  end

  // Relock write itself is not gated by its own save pulse
  assign busy_core = load_pending || await_engine || busy_sync2;
  assign corr_store_busy = busy_core || corr_save_start;
  assign corr_write_allow = key_open;
  assign corr_save_start = relock;
  assign thermo_read_start = launch;
  assign irq_ack_mode = cfg_ack_read ? gmc_pkg::GMC_ACK_READ : gmc_pkg::GMC_ACK_WRITE;
  assign dma_big_endian = cfg_dma_big;
  assign front_pull_select = gmc_pkg::gmc_pull_t'(front_pull);
  assign rear_pull_select = gmc_pkg::gmc_pull_t'(rear_pull);

  gmc_tick_div #(
    .PERIOD(AUTO_PERIOD)
  ) gmc_tick_div_i (
    .mclk(mclk),
    .nrst(nrst),
    .run(thermo_auto_sample),
    .tick(auto_tick)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_ack_read <= 1'b0;
      cfg_dma_big <= 1'b0;
    end else if (reg_wr && sel_cfg) begin
      cfg_ack_read <= reg_wdata[`GMC_BIT_ACK_MODE];
      cfg_dma_big <= reg_wdata[`GMC_BIT_DMA_ENDIAN];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      front_pull <= `GMC_RST_PULL;
      rear_pull <= `GMC_RST_PULL;
    end else begin
      if (reg_wr && sel_front) front_pull <= reg_wdata[1:0];
      if (reg_wr && sel_rear) rear_pull <= reg_wdata[1:0];
    end
  end

  // Load runs once after reset; held busy until the engine reports it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      load_pending <= 1'b1;
      corr_load_start <= 1'b0;
    end else begin
      corr_load_start <= 1'b0;
      if (load_pending && !busy_sync2 && !corr_load_start) begin
        corr_load_start <= 1'b1;
      end
      if (corr_load_start) load_pending <= 1'b0;
    end
  end

  // Bridges the sync delay so busy never dips before the engine answers
  // Limitation: an engine that never raises busy keeps the store busy until reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      await_engine <= 1'b0;
    end else if (corr_load_start || corr_save_start) begin
      await_engine <= 1'b1;
    end else if (busy_sync2) begin
      await_engine <= 1'b0;
    end
  end

  // Key cannot change while the store is busy; a stray write would corrupt an update
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      corr_write_key <= `GMC_RST_CORR_KEY;
    end else if (wr_corr && !busy_core) begin
      corr_write_key <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      thermo_auto_sample <= 1'b0;
    end else if (wr_trig) begin
      thermo_auto_sample <= reg_wdata[`GMC_BIT_AUTO_SAMPLE];
    end
  end

  // Go bit stays set until the result lands; a new go write wins over done
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      thermo_sample_go <= 1'b0;
      thermo_in_flight <= 1'b0;
    end else begin
      if (launch) thermo_in_flight <= 1'b1;
      else if (thermo_done) thermo_in_flight <= 1'b0;
      if (go_write) thermo_sample_go <= 1'b1;
      else if (thermo_done) thermo_sample_go <= 1'b0;
    end
  end

  // Result kept raw: value/256 is degrees Celsius
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      thermo_data <= 32'h0000_0000;
    end else if (thermo_done && thermo_in_flight) begin
      thermo_data <= {{19{thermo_result[12]}}, thermo_result};
    end
  end

  // Set wins over clear in both styles
  logic [NUM_IRQ-1:0] irq_set;
  logic [NUM_IRQ-1:0] irq_clr;
  assign irq_set = irq_event & irq_enable;
  assign irq_clr = cfg_ack_read ? (irq_status_rd ? irq_status : '0)
                                : (irq_status_wr ? irq_status_wdata : '0);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // Read mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  assign rd_mux =
    sel_cfg ? {30'h0, cfg_ack_read, cfg_dma_big} :
    sel_front ? {30'h0, front_pull} :
    sel_rear ? {30'h0, rear_pull} :
    sel_corr ? {15'h0, corr_store_busy, corr_write_key} :
    sel_trig ? {30'h0, thermo_auto_sample, thermo_sample_go} :
    sel_data ? thermo_data :
    sel_fw ? FIRMWARE_BUILD_ID :
    32'h0000_0000;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end
endmodule : gmc_regs

// ### tb/gmc_regs_properties.sv
// Port assertions for the global misc register bank
`timescale 1ns/100ps
module gmc_regs_chk #(
  parameter logic [31:0] FIRMWARE_BUILD_ID = 32'h0001_0000,
  parameter int NUM_IRQ = 20
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic dma_big_endian,
  input wire gmc_pkg::gmc_ack_t irq_ack_mode,
  input wire gmc_pkg::gmc_pull_t front_pull_select,
  input wire logic [NUM_IRQ-1:0] irq_event,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic irq_status_wr,
  input wire logic irq_status_rd,
  input wire logic [NUM_IRQ-1:0] irq_status_wdata,
  input wire logic [NUM_IRQ-1:0] irq_status,
  input wire logic corr_write_allow,
  input wire logic corr_save_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire [NUM_IRQ-1:0] arm = irq_event & irq_enable;
  wire [NUM_IRQ-1:0] wclr = {NUM_IRQ{irq_status_wr}} & irq_status_wdata;
  wire corr_wr = reg_wr && reg_addr == 12'h3a4;
  a_endian_write: assert property (reg_wr && reg_addr == 12'h398 |=>
    dma_big_endian == $past(reg_wdata[0])) else $error("endian bit not taken");
  a_ack_write: assert property (reg_wr && reg_addr == 12'h398 |=>
    irq_ack_mode == $past(reg_wdata[1])) else $error("ack mode not taken");
  a_front_write: assert property (reg_wr && reg_addr == 12'h39c |=>
    front_pull_select == $past(reg_wdata[1:0])) else $error("front pull not taken");
  a_relock_save: assert property (corr_save_start |-> corr_wr
    && corr_write_allow && reg_wdata[15:0] != 16'habcd) else $error("stray save start");
  a_allow_cause: assert property ($changed(corr_write_allow) |->
    $past(corr_wr)) else $error("write allow moved alone");
  a_temp_sign: assert property (reg_rd && reg_addr == 12'h3ac |=>
    reg_rdata[31:12] == {20{reg_rdata[12]}}) else $error("temperature not sign extended");
  a_fw_read: assert property (reg_rd && reg_addr == 12'h3fc |=>
    reg_rdata == FIRMWARE_BUILD_ID) else $error("firmware id wrong");
  a_status_set: assert property ((irq_status & ~$past(irq_status) & ~$past(arm)) == '0)
    else $error("status set without enabled event");
  a_write_clear: assert property (irq_ack_mode == gmc_pkg::GMC_ACK_WRITE |=>
    ($past(irq_status) & ~irq_status & ~$past(wclr)) == '0) else $error("bad write clear");
  a_read_clear: assert property (irq_ack_mode == gmc_pkg::GMC_ACK_READ && irq_status_rd |=>
    (irq_status & $past(irq_status) & ~$past(arm)) == '0) else $error("read did not clear");
  c_save: cover property (corr_save_start);
  c_read_clear: cover property (irq_status_rd && irq_status != '0);
  c_write_clear: cover property (irq_status_wr && (irq_status & irq_status_wdata) != '0);
endmodule : gmc_regs_chk
bind gmc_regs gmc_regs_chk #(.FIRMWARE_BUILD_ID(FIRMWARE_BUILD_ID), .NUM_IRQ(NUM_IRQ))
  gmc_regs_chk_i (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dma_big_endian(dma_big_endian),
    .irq_ack_mode(irq_ack_mode), .front_pull_select(front_pull_select),
    .irq_event(irq_event), .irq_enable(irq_enable), .irq_status_wr(irq_status_wr),
    .irq_status_rd(irq_status_rd), .irq_status_wdata(irq_status_wdata),
    .irq_status(irq_status), .corr_write_allow(corr_write_allow),
    .corr_save_start(corr_save_start)
  );

// ### tb/gmc_regs_tb.sv
// Self-checking bench for the global misc register bank
`timescale 1ns/100ps
module gmc_regs_tb;
  // Arbitrary build id
  localparam logic [31:0] FW = 32'h0102_0304;
  logic mclk, nrst, reg_wr, reg_rd, irq_status_wr, irq_status_rd, thermo_done;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [19:0] irq_event, irq_enable, irq_status_wdata, irq_status;
  logic [12:0] thermo_result;
  logic dma_big_endian, corr_write_allow, corr_load_start, corr_save_start, thermo_read_start;
  gmc_pkg::gmc_ack_t irq_ack_mode;
  gmc_pkg::gmc_pull_t front_pull_select, rear_pull_select;
  int err_count = 0, num_checks = 0, cyc = 0, ecnt = 0, tcnt = 0;
  logic [11:0] radr [7] = '{12'h398, 12'h39c, 12'h3a0, 12'h3a4, 12'h3a8, 12'h3ac, 12'h3fc};
  wire corr_engine_busy = ecnt != 0;
  // Short auto period keeps the run brief
  gmc_regs #(.FIRMWARE_BUILD_ID(FW), .AUTO_PERIOD(20)) gmc_regs_i (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dma_big_endian(dma_big_endian),
    .irq_ack_mode(irq_ack_mode), .front_pull_select(front_pull_select),
    .rear_pull_select(rear_pull_select), .irq_event(irq_event), .irq_enable(irq_enable),
    .irq_status_wr(irq_status_wr), .irq_status_rd(irq_status_rd),
    .irq_status_wdata(irq_status_wdata), .irq_status(irq_status),
    .corr_write_allow(corr_write_allow), .corr_load_start(corr_load_start),
    .corr_save_start(corr_save_start), .corr_engine_busy(corr_engine_busy),
    .thermo_read_start(thermo_read_start), .thermo_done(thermo_done),
    .thermo_result(thermo_result)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Engine and sensor stand-ins answer a few cycles after each start
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (corr_load_start || corr_save_start) ecnt <= 6;
    else if (ecnt != 0) ecnt <= ecnt - 1;
    if (thermo_read_start) tcnt <= 4;
    else if (tcnt != 0) tcnt <= tcnt - 1;
    thermo_done <= tcnt == 2;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    @(negedge mclk);
  endtask : rd
  task automatic irq_op(input logic [19:0] ev, input logic [19:0] d, input logic w, input logic r);
    irq_event = ev;
    irq_status_wdata = d;
    irq_status_wr = w;
    irq_status_rd = r;
    @(negedge mclk);
    irq_event = '0;
    irq_status_wr = 1'b0;
    irq_status_rd = 1'b0;
    @(negedge mclk);
  endtask : irq_op
  task automatic idle();
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 100 && ecnt != 0; i++) @(negedge mclk);
    // Busy passes two sync flops
    repeat (4) @(negedge mclk);
  endtask : idle
  task automatic close_out();
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, thermo_result} = '0;
    {irq_event, irq_enable, irq_status_wr, irq_status_rd, irq_status_wdata} = '0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    rd(12'h3a4, 32'h0001_0000);
    idle();
    for (int i = 0; i < 7; i++) rd(radr[i], i == 6 ? FW : '0);
    wr(12'h398, 32'hffff_ffff);
    rd(12'h398, 32'h3);
    chk(dma_big_endian, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(12'h39c, 32'hffff_fffc | 32'(i));
      wr(12'h3a0, 32'(3 - i));
      rd(12'h39c, 32'(i));
      rd(12'h3a0, 32'(3 - i));
      chk({front_pull_select, rear_pull_select}, {i[1:0], 2'(3 - i)});
    end
    wr(12'h3b0, 32'hffff_ffff);
    rd(12'h3b0, '0);
    wr(12'h3a4, 32'h0000_abcd);
    rd(12'h3a4, 32'h0000_abcd);
    chk(corr_write_allow, 1'b1);
    wr(12'h3a4, 32'h0000_1234);
    rd(12'h3a4, 32'h0001_1234);
    chk(corr_write_allow, 1'b0);
    // Key write during the update is ignored
    wr(12'h3a4, 32'h0000_abcd);
    rd(12'h3a4, 32'h0001_1234);
    idle();
    rd(12'h3a4, 32'h0000_1234);
    thermo_result = 13'h1f00;
    wr(12'h3a8, 32'h1);
    rd(12'h3a8, 32'h1);
    repeat (4) @(negedge mclk);
    rd(12'h3a8, '0);
    rd(12'h3ac, 32'hffff_ff00);
    thermo_result = 13'h0a80;
    wr(12'h3a8, 32'h2);
    rd(12'h3ac, 32'hffff_ff00);
    repeat (30) @(negedge mclk);
    rd(12'h3ac, 32'h0000_0a80);
    wr(12'h3a8, '0);
    wr(12'h398, '0);
    irq_enable = 20'h00001;
    irq_op(20'h3, '0, 1'b0, 1'b0);
    chk(irq_status, 20'h1);
    irq_op('0, 20'h2, 1'b1, 1'b0);
    chk(irq_status, 20'h1);
    irq_op('0, '0, 1'b0, 1'b1);
    chk(irq_status, 20'h1);
    irq_op('0, 20'h1, 1'b1, 1'b0);
    chk(irq_status, '0);
    wr(12'h398, 32'h2);
    chk(irq_ack_mode, 1'b1);
    irq_op(20'h1, '0, 1'b0, 1'b0);
    chk(irq_status, 20'h1);
    // Event and read in one cycle: the set wins
    irq_op(20'h1, '0, 1'b0, 1'b1);
    chk(irq_status, 20'h1);
    irq_op('0, '0, 1'b0, 1'b1);
    chk(irq_status, '0);
    // Bus reset in mid run reloads the store and clears the registers
    nrst = 1'b0;
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    rd(12'h3a4, 32'h0001_0000);
    rd(12'h398, '0);
    rd(12'h3ac, '0);
    idle();
    rd(12'h3a4, '0);
    close_out();
  end
endmodule : gmc_regs_tb
